// ==== core/rdcb_drop_counter.sv ====
// Dropped receive frame tally with clear on read and halfway event
`include "rdcb_params.svh"
module rdcb_drop_counter (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        inc,
  input  wire logic        clr,
  output logic [31:0]      count,
  output logic             half_evt
);
  typedef struct packed {
    logic [31:0] count;
    logic        half;
  } rdcb_cnt_s;

  rdcb_cnt_s s_reg;
  rdcb_cnt_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.half = 1'b0;
    if (clr) begin
      s_next.count = {31'h0000_0000, inc};
    end else if (inc) begin
      s_next.count = s_reg.count + 32'h0000_0001;
      s_next.half = (s_reg.count == 32'h7fff_ffff);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '{count: `RDCB_RST_DROP, half: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign count    = s_reg.count;
  assign half_evt = s_reg.half;
endmodule : rdcb_drop_counter

// ==== core/rdcb_flow_ctrl.sv ====
// Dropped-frame tally, MAC CSR indirect access bridge and automatic flow control
`include "rdcb_params.svh"
module rdcb_flow_ctrl #(
  parameter int FIFO_W    = 14,
  parameter int JAM_CNT_W = 20,
  parameter int JAM_UNIT  = `RDCB_JAM_UNIT_NS
) (
  input  wire logic              CLK,
  input  wire logic              RST,
  // ----------------------------------------------------------------------------
  // Host register port
  // ----------------------------------------------------------------------------
  input  wire logic [7:0]        HOST_ADDR,
  input  wire logic              HOST_WR,
  input  wire logic              HOST_RD,
  input  wire logic [31:0]       HOST_WDATA,
  output logic [31:0]            HOST_RDATA,
  output logic                   HOST_RVALID,
  // ----------------------------------------------------------------------------
  // MAC CSR side
  // ----------------------------------------------------------------------------
  output logic                   MAC_CSR_REQ,
  output logic                   MAC_CSR_READ_NOT_WRITE,
  output logic [7:0]             MAC_CSR_INDEX,
  output logic [31:0]            MAC_CSR_WDATA,
  input  wire logic              MAC_CSR_ACK,
  input  wire logic [31:0]       MAC_CSR_RDATA,
  input  wire logic [15:0]       PAUSE_TIME_VALUE,
  // ----------------------------------------------------------------------------
  // Receive path status
  // ----------------------------------------------------------------------------
  input  wire logic              RX_FRAME_DROPPED,
  input  wire logic [FIFO_W-1:0] RX_FIFO_USED,
  input  wire logic              RX_PREAMBLE,
  input  wire logic              RX_ADDR_DONE,
  input  wire logic              RX_IS_MULTICAST,
  input  wire logic              RX_IS_BROADCAST,
  input  wire logic              RX_IS_OWN_ADDRESS,
  output logic                   DROP_HALFWAY_EVENT,
  // ----------------------------------------------------------------------------
  // MAC transmit side
  // ----------------------------------------------------------------------------
  input  wire logic              TX_ENABLED,
  input  wire logic              FULL_DUPLEX,
  input  wire logic              SPEED_100,
  output logic                   PAUSE_REQ,
  output logic [15:0]            PAUSE_TIME,
  input  wire logic              PAUSE_ACK,
  output logic                   BACKPRESSURE
);

  // ----------------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------------
  initial begin
    if (FIFO_W < 8 + `RDCB_LEVEL_SHIFT || FIFO_W > 24) begin
      $error("rdcb_flow_ctrl: FIFO_W out of range");
    end
  end

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic [FIFO_W:0] rdcb_level_bytes(input logic [7:0] lvl);
    return (FIFO_W + 1)'({lvl, 6'h00});
  endfunction : rdcb_level_bytes

  function automatic logic rdcb_hit(input logic [7:0] a, input logic wr, input logic [7:0] ofs);
    return wr && (a == ofs);
  endfunction : rdcb_hit

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  rdcb_pkg::rdcb_top_s s_reg;
  rdcb_pkg::rdcb_top_s s_next;

  logic [31:0]   drop_count;
  logic          drop_half;
  logic          drop_clr;
  logic          jam_start;
  logic          jam_stop;
  logic          jam_active;

  // ----------------------------------------------------------------------------
  // Derived configuration
  // ----------------------------------------------------------------------------
  logic [7:0]    cfg_high;
  logic [7:0]    cfg_low;
  logic [3:0]    cfg_dur;
  logic          cfg_mult;
  logic          cfg_brd;
  logic          cfg_add;
  logic          cfg_any;
  logic          auto_enabled;
  logic          high_reached;
  logic          below_low;
  logic          frame_match;

  assign cfg_high     = s_reg.afc[`RDCB_HIGH_MSB:`RDCB_HIGH_LSB];
  assign cfg_low      = s_reg.afc[`RDCB_LOW_MSB:`RDCB_LOW_LSB];
  assign cfg_dur      = s_reg.afc[`RDCB_AFC_DUR_MSB:`RDCB_AFC_DUR_LSB];
  assign cfg_mult     = s_reg.afc[`RDCB_AFC_MULT_BIT];
  assign cfg_brd      = s_reg.afc[`RDCB_AFC_BRD_BIT];
  assign cfg_add      = s_reg.afc[`RDCB_AFC_ADD_BIT];
  assign cfg_any      = s_reg.afc[`RDCB_AFC_ANY_BIT];
  assign auto_enabled = cfg_any | cfg_mult | cfg_brd | cfg_add;

  // Level compare in bytes
  assign high_reached = {1'b0, RX_FIFO_USED} >= rdcb_level_bytes(cfg_high);
  assign below_low    = {1'b0, RX_FIFO_USED} < rdcb_level_bytes(cfg_low);

  // Half-duplex frame match
  always_comb begin
    frame_match = 1'b0;
    if (cfg_any) begin
      frame_match = RX_PREAMBLE;
    end else if (RX_ADDR_DONE) begin
      frame_match = (cfg_mult & RX_IS_MULTICAST)
                  | (cfg_brd & RX_IS_BROADCAST)
                  | (cfg_add & RX_IS_OWN_ADDRESS);
    end
  end

  assign jam_start = TX_ENABLED && !FULL_DUPLEX && high_reached && frame_match;
  assign jam_stop  = !TX_ENABLED || FULL_DUPLEX;

  // ----------------------------------------------------------------------------
  // Dropped frame tally
  // ----------------------------------------------------------------------------
  assign drop_clr = HOST_RD && (HOST_ADDR == `RDCB_OFS_DROP);

  rdcb_drop_counter i_rdcb_drop_counter (
    .clk      (CLK),
    .rst      (RST),
    .inc      (RX_FRAME_DROPPED),
    .clr      (drop_clr),
    .count    (drop_count),
    .half_evt (drop_half)
  );

  // ----------------------------------------------------------------------------
  // Backpressure timer
  // ----------------------------------------------------------------------------
  rdcb_jam_timer #(
    .CNT_W   (JAM_CNT_W),
    .UNIT_NS (JAM_UNIT)
  ) i_rdcb_jam_timer (
    .clk       (CLK),
    .rst       (RST),
    .start     (jam_start),
    .stop      (jam_stop),
    .code      (cfg_dur),
    .speed_100 (SPEED_100),
    .active    (jam_active)
  );

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.rd_valid = 1'b0;

    // Host read data, reserved bits zero
    if (HOST_RD) begin
      s_next.rd_valid = 1'b1;
      unique case (HOST_ADDR)
        `RDCB_OFS_DROP: begin
          s_next.rdata = drop_count;
        end
        `RDCB_OFS_CMD: begin
          s_next.rdata = {s_reg.busy, s_reg.rnw, 22'h00_0000, s_reg.index};
        end
        `RDCB_OFS_DATA: begin
          s_next.rdata = s_reg.data;
        end
        `RDCB_OFS_AFC: begin
          s_next.rdata = {8'h00, s_reg.afc};
        end
        default: begin
          s_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Host writes; command and data held while busy
    if (!s_reg.busy) begin
      if (rdcb_hit(HOST_ADDR, HOST_WR, `RDCB_OFS_CMD)) begin
        s_next.rnw   = HOST_WDATA[`RDCB_CMD_RNW_BIT];
        s_next.index = HOST_WDATA[`RDCB_CMD_IDX_HI:`RDCB_CMD_IDX_LO];
        if (HOST_WDATA[`RDCB_CMD_BUSY_BIT]) begin
          s_next.busy    = 1'b1;
          s_next.mac_req = 1'b1;
        end
      end
      if (rdcb_hit(HOST_ADDR, HOST_WR, `RDCB_OFS_DATA)) begin
        s_next.data = HOST_WDATA;
      end
    end
    if (rdcb_hit(HOST_ADDR, HOST_WR, `RDCB_OFS_AFC)) begin
      s_next.afc = HOST_WDATA[23:0];
    end

    // MAC CSR access completion
    if (s_reg.mac_req && MAC_CSR_ACK) begin
      s_next.mac_req = 1'b0;
      s_next.busy    = 1'b0;
      if (s_reg.rnw) begin
        s_next.data = MAC_CSR_RDATA;
      end
    end

    // Pause frame handshake
    if (s_reg.pause_req && PAUSE_ACK) begin
      s_next.pause_req = 1'b0;
    end

    // Full-duplex pause control
    unique case (s_reg.fc_state)
      rdcb_pkg::FC_IDLE: begin
        if (FULL_DUPLEX && TX_ENABLED && cfg_any && high_reached && !s_reg.pause_req) begin
          s_next.pause_req  = 1'b1;
          s_next.pause_time = PAUSE_TIME_VALUE;
          s_next.fc_state   = rdcb_pkg::FC_PAUSED;
        end
      end
      rdcb_pkg::FC_PAUSED: begin
        if (!auto_enabled || !FULL_DUPLEX) begin
          s_next.fc_state = rdcb_pkg::FC_IDLE;
        end else if (TX_ENABLED && below_low && !s_reg.pause_req) begin
          s_next.pause_req  = 1'b1;
          s_next.pause_time = 16'h0000;
          s_next.fc_state   = rdcb_pkg::FC_IDLE;
        end
      end
    endcase

    // Transmitter off withdraws any pending pause
    if (!TX_ENABLED) begin
      s_next.pause_req = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      s_reg <= '{
        busy:       1'b0,
        rnw:        1'b0,
        index:      `RDCB_RST_INDEX,
        data:       `RDCB_RST_DATA,
        afc:        `RDCB_RST_AFC,
        rdata:      32'h0000_0000,
        rd_valid:   1'b0,
        mac_req:    1'b0,
        pause_req:  1'b0,
        pause_time: 16'h0000,
        fc_state:   rdcb_pkg::FC_IDLE
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign HOST_RDATA             = s_reg.rdata;
  assign HOST_RVALID            = s_reg.rd_valid;
  assign MAC_CSR_REQ            = s_reg.mac_req;
  assign MAC_CSR_READ_NOT_WRITE = s_reg.rnw;
  assign MAC_CSR_INDEX          = s_reg.index;
  assign MAC_CSR_WDATA          = s_reg.data;
  assign DROP_HALFWAY_EVENT     = drop_half;
  assign PAUSE_REQ              = s_reg.pause_req;
  assign PAUSE_TIME             = s_reg.pause_time;
  assign BACKPRESSURE           = jam_active;

endmodule : rdcb_flow_ctrl

// ==== core/rdcb_jam_timer.sv ====
// Backpressure duration timer
`include "rdcb_params.svh"
module rdcb_jam_timer #(
  parameter int CNT_W   = 20,
  parameter int UNIT_NS = `RDCB_JAM_UNIT_NS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [3:0]  code,
  input  wire logic        speed_100,
  output logic             active
);
  typedef struct packed {
    logic [CNT_W-1:0] left;
    logic             active;
  } rdcb_jam_s;

  rdcb_jam_s s_reg;
  rdcb_jam_s s_next;

  function automatic logic [CNT_W-1:0] rdcb_jam_cycles(input logic [3:0] c, input logic fast);
    int tenths;
    tenths = (c < 4'h3) ? 50 * (int'(c) + 1) : ((c == 4'h3) ? 250 : 500 * (int'(c) - 3));
    if (!fast) begin
      tenths = tenths + `RDCB_JAM_10M_EXTRA;
    end
    return CNT_W'((tenths * UNIT_NS) / `RDCB_CLK_NS);
  endfunction : rdcb_jam_cycles

  initial begin
    if (CNT_W < 8 || CNT_W > 31 || UNIT_NS < `RDCB_CLK_NS) begin
      $error("rdcb_jam_timer: unsupported parameters");
    end
  end

  always_comb begin
    s_next = s_reg;
    if (stop) begin
      s_next.active = 1'b0;
      s_next.left = '0;
    end else if (start) begin
      s_next.active = 1'b1;
      s_next.left = rdcb_jam_cycles(code, speed_100);
    end else if (s_reg.active) begin
      s_next.left = s_reg.left - CNT_W'(1);
      s_next.active = (s_reg.left > CNT_W'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '{left: '0, active: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign active = s_reg.active;
endmodule : rdcb_jam_timer

// ==== core/rdcb_params.svh ====
// Offsets, field positions, reset values and timing constants of the control block
// ----------------------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------------------
`ifndef RDCB_PARAMS_SVH
`define RDCB_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RDCB_OFS_DROP       8'ha0
`define RDCB_OFS_CMD        8'ha4
`define RDCB_OFS_DATA       8'ha8
`define RDCB_OFS_AFC        8'hac

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RDCB_CMD_BUSY_BIT   31
`define RDCB_CMD_RNW_BIT    30
`define RDCB_CMD_IDX_HI     7
`define RDCB_CMD_IDX_LO     0
`define RDCB_HIGH_MSB       23
`define RDCB_HIGH_LSB       16
`define RDCB_LOW_MSB        15
`define RDCB_LOW_LSB        8
`define RDCB_AFC_DUR_MSB    7
`define RDCB_AFC_DUR_LSB    4
`define RDCB_AFC_MULT_BIT   3
`define RDCB_AFC_BRD_BIT    2
`define RDCB_AFC_ADD_BIT    1
`define RDCB_AFC_ANY_BIT    0
`define RDCB_LEVEL_SHIFT    6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RDCB_RST_DROP       32'h0000_0000
`define RDCB_RST_DATA       32'h0000_0000
`define RDCB_RST_INDEX      8'h00
`define RDCB_RST_AFC        24'h00_0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RDCB_CLK_NS         8
`define RDCB_JAM_UNIT_NS    100
`define RDCB_JAM_10M_EXTRA  22

`endif

// ==== core/rdcb_pkg.sv ====
// Types shared by the control block modules
package rdcb_pkg;

  typedef enum logic [0:0] {
    FC_IDLE,
    FC_PAUSED
  } rdcb_fc_e;

  typedef struct packed {
    logic        busy;
    logic        rnw;
    logic [7:0]  index;
    logic [31:0] data;
    logic [23:0] afc;
    logic [31:0] rdata;
    logic        rd_valid;
    logic        mac_req;
    logic        pause_req;
    logic [15:0] pause_time;
    rdcb_fc_e    fc_state;
  } rdcb_top_s;

endpackage : rdcb_pkg

// ==== sim/rdcb_flow_ctrl_monitor.sv ====
// Concurrent checks on the ports of the control block
module rdcb_flow_ctrl_monitor #(
  parameter int FIFO_W = 14
) (
  input wire logic              CLK,
  input wire logic              RST,
  input wire logic [7:0]        HOST_ADDR,
  input wire logic              HOST_WR,
  input wire logic              HOST_RD,
  input wire logic [31:0]       HOST_WDATA,
  input wire logic [31:0]       HOST_RDATA,
  input wire logic              HOST_RVALID,
  input wire logic              MAC_CSR_REQ,
  input wire logic              MAC_CSR_READ_NOT_WRITE,
  input wire logic [7:0]        MAC_CSR_INDEX,
  input wire logic [31:0]       MAC_CSR_WDATA,
  input wire logic              MAC_CSR_ACK,
  input wire logic [31:0]       MAC_CSR_RDATA,
  input wire logic [15:0]       PAUSE_TIME_VALUE,
  input wire logic [FIFO_W-1:0] RX_FIFO_USED,
  input wire logic              RX_PREAMBLE,
  input wire logic              TX_ENABLED,
  input wire logic              FULL_DUPLEX,
  input wire logic              PAUSE_REQ,
  input wire logic [15:0]       PAUSE_TIME,
  input wire logic              BACKPRESSURE
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------------
  // Shadow of the flow control settings
  // ----------------------------------------------------------------------------
  logic [23:0] afc_reg;
  always_ff @(posedge CLK) begin
    if (RST) begin
      afc_reg <= 24'h00_0000;
    end else if (HOST_WR && HOST_ADDR == 8'hac) begin
      afc_reg <= HOST_WDATA[23:0];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  a_read_answer: assert property (HOST_RVALID == $past(HOST_RD))
    else $error("read answer not one cycle after strobe");
  a_start_access: assert property (HOST_WR && HOST_ADDR == 8'ha4 && HOST_WDATA[31] && !MAC_CSR_REQ
    |=> MAC_CSR_REQ && MAC_CSR_INDEX == $past(HOST_WDATA[7:0])
    && MAC_CSR_READ_NOT_WRITE == $past(HOST_WDATA[30]))
    else $error("indirect access not started");
  a_hold_access: assert property (MAC_CSR_REQ && !MAC_CSR_ACK |=> MAC_CSR_REQ
    && $stable(MAC_CSR_INDEX) && $stable(MAC_CSR_WDATA) && $stable(MAC_CSR_READ_NOT_WRITE))
    else $error("indirect access changed before acknowledge");
  a_end_access: assert property (MAC_CSR_REQ && MAC_CSR_ACK |=> !MAC_CSR_REQ)
    else $error("indirect access not ended");
  a_read_data: assert property (MAC_CSR_REQ && MAC_CSR_ACK && MAC_CSR_READ_NOT_WRITE
    |=> MAC_CSR_WDATA == $past(MAC_CSR_RDATA))
    else $error("indirect read data not in data register");
  a_data_read: assert property (HOST_RD && HOST_ADDR == 8'ha8
    |=> HOST_RDATA == $past(MAC_CSR_WDATA))
    else $error("data register read returned wrong value");
  a_tx_off: assert property (!TX_ENABLED |=> !PAUSE_REQ && !BACKPRESSURE)
    else $error("flow control while transmitter disabled");
  a_pause_time: assert property ($rose(PAUSE_REQ) |-> PAUSE_TIME == 16'h0000
    || PAUSE_TIME == $past(PAUSE_TIME_VALUE))
    else $error("pause time neither zero nor programmed value");
  a_full_nojam: assert property (FULL_DUPLEX |=> !BACKPRESSURE)
    else $error("jam in full duplex");
  a_any_frame: assert property (TX_ENABLED && !FULL_DUPLEX && afc_reg[0] && RX_PREAMBLE
    && RX_FIFO_USED >= {afc_reg[23:16], 6'h00} |=> BACKPRESSURE)
    else $error("no jam on preamble above high level");
  c_read: cover property (HOST_RVALID);
  c_access: cover property (MAC_CSR_REQ && MAC_CSR_ACK);
  c_pause: cover property ($rose(PAUSE_REQ));
  c_jam: cover property ($rose(BACKPRESSURE));
endmodule : rdcb_flow_ctrl_monitor

bind rdcb_flow_ctrl rdcb_flow_ctrl_monitor #(.FIFO_W(FIFO_W)) i_rdcb_flow_ctrl_monitor (
  .CLK(CLK), .RST(RST), .HOST_ADDR(HOST_ADDR), .HOST_WR(HOST_WR), .HOST_RD(HOST_RD),
  .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA), .HOST_RVALID(HOST_RVALID),
  .MAC_CSR_REQ(MAC_CSR_REQ), .MAC_CSR_READ_NOT_WRITE(MAC_CSR_READ_NOT_WRITE),
  .MAC_CSR_INDEX(MAC_CSR_INDEX), .MAC_CSR_WDATA(MAC_CSR_WDATA), .MAC_CSR_ACK(MAC_CSR_ACK),
  .MAC_CSR_RDATA(MAC_CSR_RDATA), .PAUSE_TIME_VALUE(PAUSE_TIME_VALUE),
  .RX_FIFO_USED(RX_FIFO_USED), .RX_PREAMBLE(RX_PREAMBLE), .TX_ENABLED(TX_ENABLED),
  .FULL_DUPLEX(FULL_DUPLEX), .PAUSE_REQ(PAUSE_REQ), .PAUSE_TIME(PAUSE_TIME),
  .BACKPRESSURE(BACKPRESSURE)
);

// ==== sim/rdcb_mac_model.sv ====
// Behavioural MAC side: CSR space and pause frame transmitter
module rdcb_mac_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  ack_dly,
  input  wire logic        req,
  input  wire logic        rnw,
  input  wire logic [7:0]  index,
  input  wire logic [31:0] wdata,
  output logic             ack,
  output logic [31:0]      rdata,
  input  wire logic        pause_req,
  output logic             pause_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [256];
  logic [7:0]  cnt;
  logic [1:0]  pcnt;
  always @(posedge clk) begin
    ack <= 1'b0;
    pause_ack <= 1'b0;
    rdata <= ~rdata;
    if (rst) begin
      cnt <= 8'h00;
      pcnt <= 2'h0;
      rdata <= 32'h5a5a_5a5a;
    end else begin
      if (req && !ack) begin
        cnt <= cnt + 8'h01;
        if (cnt >= ack_dly) begin
          ack <= 1'b1;
          cnt <= 8'h00;
          if (rnw) begin
            rdata <= mem[index];
          end else begin
            mem[index] <= wdata;
          end
        end
      end
      if (pause_req && !pause_ack) begin
        pcnt <= pcnt + 2'h1;
        if (pcnt == 2'h2) begin
          pause_ack <= 1'b1;
          pcnt <= 2'h0;
        end
      end
    end
  end
endmodule : rdcb_mac_model

// ==== sim/test_rx_drop_csr_bridge_flow_ctrl.sv ====
// Self-checking bench for the control block
module test_rx_drop_csr_bridge_flow_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst = 1'b1, host_wr = 1'b0, host_rd = 1'b0;
  logic [7:0]  host_addr = 8'h00, ack_dly = 8'h00;
  logic [31:0] host_wdata = 32'h0, host_rdata, wdata, rdata;
  logic        drop = 1'b0, pre = 1'b0, adone = 1'b0, tx = 1'b0, fd = 1'b0, spd = 1'b1;
  logic [2:0]  flags = 3'h0;
  logic [13:0] used = 14'h0;
  logic [15:0] ptv = 16'h0, pause_time;
  logic [7:0]  index;
  logic        rvalid, req, rnw, ack, pause_req, pause_ack, bp, half;
  logic        half_seen = 1'b0;
  int          miscompares = 0, tests_run = 0;
  int          len [1:3] = '{122, 500, 50};
  logic [3:0]  code [1:3] = '{4'h1, 4'h4, 4'h0};
  logic [7:0]  regs [5] = '{8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hb0};

  rdcb_flow_ctrl #(.JAM_UNIT(8)) i_rdcb_flow_ctrl (
    .CLK(clk), .RST(rst), .HOST_ADDR(host_addr), .HOST_WR(host_wr), .HOST_RD(host_rd),
    .HOST_WDATA(host_wdata), .HOST_RDATA(host_rdata), .HOST_RVALID(rvalid),
    .MAC_CSR_REQ(req), .MAC_CSR_READ_NOT_WRITE(rnw), .MAC_CSR_INDEX(index),
    .MAC_CSR_WDATA(wdata), .MAC_CSR_ACK(ack), .MAC_CSR_RDATA(rdata),
    .PAUSE_TIME_VALUE(ptv), .RX_FRAME_DROPPED(drop), .RX_FIFO_USED(used),
    .RX_PREAMBLE(pre), .RX_ADDR_DONE(adone), .RX_IS_MULTICAST(flags[2]),
    .RX_IS_BROADCAST(flags[1]), .RX_IS_OWN_ADDRESS(flags[0]), .DROP_HALFWAY_EVENT(half),
    .TX_ENABLED(tx), .FULL_DUPLEX(fd), .SPEED_100(spd), .PAUSE_REQ(pause_req),
    .PAUSE_TIME(pause_time), .PAUSE_ACK(pause_ack), .BACKPRESSURE(bp)
  );
  rdcb_mac_model i_rdcb_mac_model (
    .clk(clk), .rst(rst), .ack_dly(ack_dly), .req(req), .rnw(rnw), .index(index),
    .wdata(wdata), .ack(ack), .rdata(rdata), .pause_req(pause_req), .pause_ack(pause_ack)
  );

  always #4 clk = ~clk;
  // Sticky record of any halfway event after reset
  always @(posedge clk) begin
    if (!rst && half !== 1'b0) begin
      half_seen <= 1'b1;
    end
  end
  // ----------------------------------------------------------------------------
  // Host access and checking tasks
  // ----------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(posedge clk);
    #1 host_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic inc, output logic [31:0] d);
    @(posedge clk);
    #1 host_rd = 1'b1;
    host_addr = a;
    drop = inc;
    @(posedge clk);
    #1 host_rd = 1'b0;
    drop = 1'b0;
    check("read valid", {31'h0, rvalid}, 32'h1);
    d = host_rdata;
  endtask : rd
  task automatic chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                     input logic inc);
    logic [31:0] d;
    rd(a, inc, d);
    check(what, d, exp);
  endtask : chk
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
  endtask : pulse
  task automatic wait_idle;
    logic [31:0] d;
    d = 32'hffff_ffff;
    for (int i = 0; i < 60 && d[31] !== 1'b0; i++) rd(8'ha4, 1'b0, d);
    check("busy clear", {31'h0, d[31]}, 32'h0);
  endtask : wait_idle
  task automatic quiet(input int n, input string what);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1 seen = seen | pause_req | bp;
    end
    check(what, {31'h0, seen}, 32'h0);
  endtask : quiet
  task automatic wait_pause(input logic [15:0] t);
    for (int i = 0; i < 20 && pause_req !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check("pause time", {15'h0, pause_req, pause_time}, {15'h0, 1'b1, t});
    repeat (8) @(posedge clk);
    #1;
  endtask : wait_pause
  task automatic jam_len(input int exp);
    int n;
    n = 0;
    while (bp === 1'b1 && n < 2000) begin
      n++;
      @(posedge clk);
      #1;
    end
    check("jam length", n, exp);
  endtask : jam_len
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    foreach (regs[i]) chk("reset value", regs[i], 32'h0, 1'b0);
    wr(8'hac, 32'hffff_feff);
    chk("flow config", 8'hac, 32'h00ff_feff, 1'b0);
    wr(8'ha4, 32'h7fff_ff05);
    chk("command", 8'ha4, 32'h4000_0005, 1'b0);
    wr(8'hb0, 32'hffff_ffff);
    chk("unmapped", 8'hb0, 32'h0, 1'b0);
    $display("test registers done");
    repeat (5) pulse(drop);
    chk("tally", 8'ha0, 32'h5, 1'b0);
    chk("tally cleared", 8'ha0, 32'h0, 1'b0);
    repeat (3) pulse(drop);
    chk("tally", 8'ha0, 32'h3, 1'b1);
    chk("tally kept", 8'ha0, 32'h1, 1'b0);
    check("halfway event", {31'h0, half_seen}, 32'h0);
    $display("test tally done");
    ack_dly = 8'h0a;
    wr(8'ha8, 32'h1234_5678);
    wr(8'ha4, 32'h8000_0011);
    chk("busy", 8'ha4, 32'h8000_0011, 1'b0);
    wr(8'ha8, 32'hdead_beef);
    wait_idle();
    chk("data kept", 8'ha8, 32'h1234_5678, 1'b0);
    wr(8'ha8, 32'h0);
    ack_dly = 8'h00;
    wr(8'ha4, 32'hc000_0011);
    wait_idle();
    chk("csr read", 8'ha8, 32'h1234_5678, 1'b0);
    $display("test indirect done");
    tx = 1'b1;
    fd = 1'b1;
    ptv = 16'h0abc;
    used = 14'd127;
    wr(8'hac, 32'h0002_01f1);
    quiet(8, "below high");
    used = 14'd128;
    wait_pause(16'h0abc);
    quiet(16, "single pause");
    used = 14'd64;
    quiet(8, "not below low");
    used = 14'd63;
    wait_pause(16'h0000);
    used = 14'd10;
    quiet(8, "single resume");
    tx = 1'b0;
    used = 14'd200;
    quiet(10, "tx off pause");
    $display("test pause done");
    fd = 1'b0;
    for (int i = 1; i <= 3; i++) begin
      tx = 1'b1;
      spd = (i != 1);
      wr(8'hac, {8'h0, 8'h02, 8'h01, code[i], 4'h1 << i});
      flags = 3'h1 << (i % 3);
      pulse(adone);
      quiet(8, "no jam other frame");
      flags = 3'h1 << (i - 1);
      pulse(adone);
      jam_len(len[i]);
    end
    wr(8'hac, 32'h0002_010f);
    pulse(pre);
    jam_len(50);
    tx = 1'b0;
    pulse(pre);
    quiet(8, "tx off jam");
    $display("test jam done");
    summarize();
  end
endmodule : test_rx_drop_csr_bridge_flow_ctrl
